// *** hw/frame_builder_pkg.sv ***
package frame_builder_pkg;

   // ==========================================================
   // Interface configuration field layout
   localparam int STATUS_EN_BIT   = 2;
   localparam logic [1:0] CHECK_OFF = 2'h0;
   localparam logic [1:0] CHECK_SUM = 2'h1;
   localparam logic [1:0] CHECK_CRC = 2'h2;

   // ==========================================================
   // Status byte bit positions
   localparam int ST_AUX_NEW   = 7;
   localparam int ST_PRI_NEW   = 6;
   localparam int ST_EXT_CLK   = 5;
   localparam int ST_LOW_REF   = 4;
   localparam int ST_AMP_LOW   = 3;
   localparam int ST_AMP_HIGH  = 2;
   localparam int ST_AMP_DIFF  = 1;
   localparam int ST_RESET     = 0;

   // ==========================================================
   // Check byte constants, frame lengths and reset values
   localparam logic [7:0] CHECKSUM_OFFSET = 8'h9B;
   localparam logic [7:0] CRC_POLY        = 8'h07;
   localparam logic [7:0] PAD_BYTE        = 8'h00;
   localparam logic [7:0] SHIFT_RESET     = 8'h00;
   localparam logic [2:0] FRAME_MAX       = 3'h6;
   localparam logic [2:0] LEN_RESET       = 3'h4;
   localparam logic [2:0] LEN_REG         = 3'h1;
   localparam logic [2:0] DATA_BYTES      = 3'h4;

endpackage

// *** hw/conversion_data_frame_builder.sv ***
`timescale 1ns/1ps
`default_nettype none
module conversion_data_frame_builder (
   input  wire logic        MCLK,
   input  wire logic        RST_B,
   input  wire logic        SCLK,
   input  wire logic        FRAME_CS_B,
   input  wire logic        LOAD,
   input  wire logic        LOAD_AUX,
   input  wire logic        LOAD_REG,
   input  wire logic [31:0] PRI_DATA,
   input  wire logic [23:0] AUX_DATA,
   input  wire logic [7:0]  REG_DATA,
   input  wire logic [7:0]  IF_CONFIG,
   input  wire logic        AUX_NEW,
   input  wire logic        PRI_NEW,
   input  wire logic        EXT_CLOCK,
   input  wire logic        LOW_REF_ALARM,
   input  wire logic        AMP_LOW_ALARM,
   input  wire logic        AMP_HIGH_ALARM,
   input  wire logic        AMP_DIFF_ALARM,
   input  wire logic        RESET_FLAG,
   output logic             DATA_OUT,
   output logic [2:0]       FRAME_LEN,
   output logic             FRAME_WRAP
);

   // ==========================================================
   // Pin synchronisers
   logic [1:0] sclk_sync_ff;
   logic [1:0] cs_sync_ff;
   logic       sclk_last_ff;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_active;

   // Two flops on the serial clock pin
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         sclk_sync_ff <= 2'h0;
      end else begin
         sclk_sync_ff <= {sclk_sync_ff[0], SCLK};
      end
   end

   // Two flops on the select pin; idles deselected
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         cs_sync_ff <= 2'h3;
      end else begin
         cs_sync_ff <= {cs_sync_ff[0], FRAME_CS_B};
      end
   end

   // Previous synced clock level, idles low so no false edge
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         sclk_last_ff <= 1'b0;
      end else begin
         sclk_last_ff <= sclk_sync_ff[1];
      end
   end

   assign sclk_rise = sclk_sync_ff[1] & ~sclk_last_ff;
   assign sclk_fall = ~sclk_sync_ff[1] & sclk_last_ff;
   assign cs_active = ~cs_sync_ff[1];

   // ==========================================================
   // Check byte computation
   function automatic logic [7:0] crc_byte(input logic [7:0] crc,
                                           input logic [7:0] data);
      logic [7:0] c;
      integer     i;
      c = crc ^ data;
      for (i = 0; i < 8; i = i + 1) begin
         if (c[7]) begin
            c = {c[6:0], 1'b0} ^ frame_builder_pkg::CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

   logic [7:0] b0;
   logic [7:0] b1;
   logic [7:0] b2;
   logic [7:0] b3;
   logic [7:0] sum_val;
   logic [7:0] crc_val;
   logic [7:0] status_val;

   assign b0 = LOAD_AUX ? AUX_DATA[23:16] : PRI_DATA[31:24];
   assign b1 = LOAD_AUX ? AUX_DATA[15:8]  : PRI_DATA[23:16];
   assign b2 = LOAD_AUX ? AUX_DATA[7:0]   : PRI_DATA[15:8];
   assign b3 = LOAD_AUX ? frame_builder_pkg::PAD_BYTE : PRI_DATA[7:0];

   // Sum and CRC over three or four data bytes
   always_comb begin
      logic [7:0] c;
      c = 8'h00;
      sum_val = 8'(b0 + b1 + b2);
      sum_val = 8'(sum_val + frame_builder_pkg::CHECKSUM_OFFSET);
      c = crc_byte(c, b0);
      c = crc_byte(c, b1);
      c = crc_byte(c, b2);
      if (!LOAD_AUX) begin
         sum_val = 8'(sum_val + b3);
         c = crc_byte(c, b3);
      end
      crc_val = c;
   end

   // Status byte assembly; alarms only in primary frames
   always_comb begin
      status_val = 8'h00;
      status_val[frame_builder_pkg::ST_AUX_NEW]  = AUX_NEW;
      status_val[frame_builder_pkg::ST_PRI_NEW]  = PRI_NEW;
      status_val[frame_builder_pkg::ST_EXT_CLK]  = EXT_CLOCK;
      status_val[frame_builder_pkg::ST_RESET]    = RESET_FLAG;
      if (!LOAD_AUX) begin
         status_val[frame_builder_pkg::ST_LOW_REF]  = LOW_REF_ALARM;
         status_val[frame_builder_pkg::ST_AMP_LOW]  = AMP_LOW_ALARM;
         status_val[frame_builder_pkg::ST_AMP_HIGH] = AMP_HIGH_ALARM;
         status_val[frame_builder_pkg::ST_AMP_DIFF] = AMP_DIFF_ALARM;
      end
   end

   // ==========================================================
   // Frame storage
   logic [7:0] frame_ff [0:5];
   logic [2:0] len_ff;
   logic [2:0] idx_ff;
   logic [2:0] bit_ff;
   logic [7:0] shift_ff;
   logic       out_ff;
   logic       wrap_ff;
   logic       st_en;
   logic       ck_en;
   logic [2:0] nxt_len;
   logic [7:0] nxt_check;
   logic       restart;
   logic       byte_done;
   logic       last_byte;

   assign st_en = IF_CONFIG[frame_builder_pkg::STATUS_EN_BIT];

   // Check mode decode; other codes drop the check byte
   always_comb begin
      case (IF_CONFIG[1:0])
         frame_builder_pkg::CHECK_SUM: begin
            ck_en     = 1'b1;
            nxt_check = sum_val;
         end
         frame_builder_pkg::CHECK_CRC: begin
            ck_en     = 1'b1;
            nxt_check = crc_val;
         end
         default: begin
            ck_en     = 1'b0;
            nxt_check = frame_builder_pkg::PAD_BYTE;
         end
      endcase
   end

   // Length: register reads are one byte, data frames four to six
   always_comb begin
      if (LOAD_REG) begin
         nxt_len = frame_builder_pkg::LEN_REG;
      end else begin
         nxt_len = 3'(frame_builder_pkg::DATA_BYTES + {2'h0, st_en} +
                       {2'h0, ck_en});
      end
   end

   // Build frame bytes, status first if enabled
   genvar g;
   generate
      for (g = 0; g < int'(frame_builder_pkg::FRAME_MAX); g = g + 1) begin : g_slot
         always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
               frame_ff[g] <= frame_builder_pkg::SHIFT_RESET;
            end else if (LOAD_REG) begin
               frame_ff[g] <= (g == 0) ? REG_DATA : 8'h00;
            end else if (LOAD || LOAD_AUX) begin
               if (st_en && g == 0) begin
                  frame_ff[g] <= status_val;
               end else begin
                  case (g - (st_en ? 1 : 0))
                     0: frame_ff[g] <= b0;
                     1: frame_ff[g] <= b1;
                     2: frame_ff[g] <= b2;
                     3: frame_ff[g] <= b3;
                     4: frame_ff[g] <= nxt_check;
                     default: frame_ff[g] <= 8'h00;
                  endcase
               end
            end
         end
      end
   endgenerate

   // Frame length register
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         len_ff <= frame_builder_pkg::LEN_RESET;
      end else if (LOAD_REG || LOAD || LOAD_AUX) begin
         len_ff <= nxt_len;
      end
   end

   // ==========================================================
   // Serial shift-out, MSB first, restarting after last byte
   assign restart   = LOAD_REG | LOAD | LOAD_AUX | ~cs_active;
   assign byte_done = sclk_fall & (bit_ff == 3'h0);
   assign last_byte = (idx_ff == 3'(len_ff - 3'h1));

   // Bit counter within the current byte
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         bit_ff <= 3'h0;
      end else if (restart) begin
         bit_ff <= 3'h0;
      end else if (sclk_rise) begin
         bit_ff <= 3'(bit_ff + 3'h1);
      end
   end

   // Byte index, back to the first byte after the last
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         idx_ff <= 3'h0;
      end else if (restart) begin
         idx_ff <= 3'h0;
      end else if (byte_done) begin
         if (last_byte) begin
            idx_ff <= 3'h0;
         end else begin
            idx_ff <= 3'(idx_ff + 3'h1);
         end
      end
   end

   // Shift register, reloaded at each byte boundary
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         shift_ff <= frame_builder_pkg::SHIFT_RESET;
      end else if (sclk_rise && !restart) begin
         if (bit_ff == 3'h0) begin
            shift_ff <= frame_ff[idx_ff];
         end else begin
            shift_ff <= {shift_ff[6:0], 1'b0};
         end
      end
   end

   // Serial output bit, MSB of each byte first
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         out_ff <= 1'b0;
      end else if (sclk_rise && !restart) begin
         if (bit_ff == 3'h0) begin
            out_ff <= frame_ff[idx_ff][7];
         end else begin
            out_ff <= shift_ff[6];
         end
      end
   end

   // One-cycle restart marker
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         wrap_ff <= 1'b0;
      end else begin
         wrap_ff <= byte_done & last_byte & ~restart;
      end
   end

   // Output registers
   assign DATA_OUT   = out_ff;
   assign FRAME_WRAP = wrap_ff;
   assign FRAME_LEN  = len_ff;

endmodule
`default_nettype wire

// *** tb/conversion_data_frame_builder_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module frame_builder_props (
   input wire logic       MCLK,
   input wire logic       RST_B,
   input wire logic       LOAD,
   input wire logic       LOAD_AUX,
   input wire logic       LOAD_REG,
   input wire logic [7:0] IF_CONFIG,
   input wire logic [2:0] FRAME_LEN,
   input wire logic       FRAME_WRAP
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   // ====
   // Frame length after each kind of load
   AST_LEN_FULL: assert property (LOAD && IF_CONFIG[2:0] == 3'h5
      |=> FRAME_LEN == 3'h6) else $error("len not 6");
   AST_LEN_STAT: assert property (LOAD && IF_CONFIG[2:0] == 3'h4
      |=> FRAME_LEN == 3'h5) else $error("len not 5");
   AST_LEN_CRC: assert property (LOAD && IF_CONFIG[2:0] == 3'h2
      |=> FRAME_LEN == 3'h5) else $error("len not 5");
   AST_LEN_NONE: assert property (LOAD && IF_CONFIG[2:0] == 3'h3
      |=> FRAME_LEN == 3'h4) else $error("len not 4");
   AST_LEN_AUX: assert property (LOAD_AUX && IF_CONFIG[2:0] == 3'h6
      |=> FRAME_LEN == 3'h6) else $error("aux len not 6");
   AST_LEN_REG: assert property (LOAD_REG
      |=> FRAME_LEN == 3'h1) else $error("reg len not 1");
   // ====
   // Length holds between loads, restart marker is one cycle
   AST_LEN_HOLD: assert property (!(LOAD || LOAD_AUX || LOAD_REG)
      |=> $stable(FRAME_LEN)) else $error("len moved");
   AST_WRAP_ONE: assert property (FRAME_WRAP
      |=> !FRAME_WRAP) else $error("wrap too long");
endmodule
`default_nettype wire

// *** tb/host_link.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_link (
   output logic      sclk,
   output logic      cs_b,
   input  wire logic data_out
);
   logic [7:0] got[$];
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
   end
   // ====
   // Frames fetched by command, so aux new flag is usable
   task automatic read(input int n);
      logic [7:0] b;
      got.delete();
      cs_b = 1'b0;
      #320;
      for (int i = 0; i < 8 * n; i++) begin
         sclk = 1'b1;
         #160;
         sclk = 1'b0;
         #160;
         b = {b[6:0], data_out};
         if (i % 8 == 7) got.push_back(b);
      end
      cs_b = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** tb/tb_conversion_data_frame_builder.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_conversion_data_frame_builder;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic [2:0]  ld = 3'h0;
   logic [7:0]  cfg = 8'h00;
   logic [31:0] pri = 32'h0;
   logic [7:0]  flags = 8'h00;
   logic        sclk;
   logic        cs_b;
   logic        dout;
   logic [2:0]  flen;
   logic        fwrap;
   int          wraps = 0;
   logic [7:0]  want[$];
   int          fail_count = 0;
   int          checks_done = 0;
   always #20 mclk = ~mclk;
   conversion_data_frame_builder DUT (
      .MCLK(mclk), .RST_B(rst_b), .SCLK(sclk), .FRAME_CS_B(cs_b),
      .LOAD(ld[2]), .LOAD_AUX(ld[1]), .LOAD_REG(ld[0]),
      .PRI_DATA(pri), .AUX_DATA(pri[31:8]), .REG_DATA(pri[31:24]),
      .IF_CONFIG(cfg), .AUX_NEW(flags[7]), .PRI_NEW(flags[6]),
      .EXT_CLOCK(flags[5]), .LOW_REF_ALARM(flags[4]),
      .AMP_LOW_ALARM(flags[3]), .AMP_HIGH_ALARM(flags[2]),
      .AMP_DIFF_ALARM(flags[1]), .RESET_FLAG(flags[0]),
      .DATA_OUT(dout), .FRAME_LEN(flen), .FRAME_WRAP(fwrap));
   host_link host (.sclk(sclk), .cs_b(cs_b), .data_out(dout));
   // Restart pulses, counted away from the launching edge
   always @(negedge mclk) if (fwrap) wraps++;
   // ====
   // Expected frame, sum and CRC worked out bytewise
   function automatic void mk(input bit aux, input logic [7:0] st);
      logic [7:0] s;
      logic [7:0] c;
      s = 8'h9B;
      c = 8'h00;
      want.delete();
      if (cfg[2]) want.push_back(aux ? st & 8'hE1 : st);
      for (int i = 3; i >= 0; i--) begin
         want.push_back(aux && i == 0 ? 8'h00 : pri[8*i +: 8]);
         if (i > 0 || !aux) begin
            s += pri[8*i +: 8];
            c ^= pri[8*i +: 8];
            for (int k = 0; k < 8; k++)
               c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
         end
      end
      if (cfg[1:0] == 2'h1) want.push_back(s);
      if (cfg[1:0] == 2'h2) want.push_back(c);
   endfunction
   task automatic chk(input string w, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic load(input logic [2:0] kind, input logic [7:0] c,
                       input logic [31:0] d, input logic [7:0] st);
      @(negedge mclk);
      cfg = c;
      pri = d;
      flags = st;
      ld = kind;
      @(negedge mclk);
      ld = 3'h0;
      repeat (4) @(negedge mclk);
   endtask
   // Two bytes past the end must restart the frame
   task automatic read_cmp(input string w);
      int n;
      n = want.size();
      chk({w, " length"}, 8'(n), {5'h00, flen});
      wraps = 0;
      host.read(n + 2);
      for (int i = 0; i < n + 2; i++)
         chk(w, want[i % n], host.got[i]);
      chk({w, " restarts"}, 8'((n + 2) / n), 8'(wraps));
   endtask
   // ====
   // Scenarios
   task automatic t_primary();
      logic [7:0] st;
      for (int i = 0; i < 8; i++) begin
         st = i[0] ? 8'hA5 : 8'h5A;
         load(3'h4, {5'h00, i[2:0]}, i[2] ? 32'h800000FF : 32'h12345678,
              st);
         mk(1'b0, st);
         read_cmp("primary");
         chk("truncated top", pri[31:24], host.got[cfg[2] ? 1 : 0]);
      end
   endtask
   // Reset in mid-run, then a checksum frame
   task automatic t_reset();
      @(negedge mclk);
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      chk("reset length", 8'h04, {5'h00, flen});
      chk("reset data", 8'h00, {7'h00, dout});
      rst_b = 1'b1;
      load(3'h4, 8'h01, 32'h12345678, 8'h01);
      mk(1'b0, 8'h01);
      read_cmp("after reset");
   endtask
   task automatic t_aux();
      for (int i = 4; i < 8; i++) begin
         load(3'h2, {5'h00, i[2:0]}, 32'hFF0001A5, 8'hFF);
         mk(1'b1, 8'hFF);
         read_cmp("aux");
      end
   endtask
   task automatic t_reg();
      load(3'h1, 8'h05, 32'hC30000FF, 8'h00);
      want = {8'hC3};
      read_cmp("register");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      t_primary();
      t_aux();
      t_reg();
      t_reset();
      close_out();
   end
   initial begin
      #2000000;
      fail_count++;
      close_out();
   end
endmodule
bind conversion_data_frame_builder frame_builder_props props_u (
   .MCLK(MCLK), .RST_B(RST_B), .LOAD(LOAD), .LOAD_AUX(LOAD_AUX),
   .LOAD_REG(LOAD_REG), .IF_CONFIG(IF_CONFIG), .FRAME_LEN(FRAME_LEN),
   .FRAME_WRAP(FRAME_WRAP));
`default_nettype wire
